// *** design/cfh_pkg.sv ***
// package: constants and types for the can frame header block
package cfh_pkg;
    // apb register map
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] IDENT_OFF = 8'h04;
    localparam logic [7:0] SDOCFG_OFF = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0C;
    localparam logic [7:0] SDOID_OFF = 8'h10;
    localparam logic [7:0] RXID_OFF = 8'h14;
    // control fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int CTRL_RTR_BIT = 2;
    localparam int CTRL_SEL_BIT = 3;
    localparam int CTRL_BAUD_LSB = 4;
    localparam logic [1:0] CTRL_BAUD_RST = 2'h0;
    // sdo identifier bases
    localparam logic [10:0] SDO_TX_BASE = 11'h580;
    localparam logic [10:0] SDO_RX_BASE = 11'h600;
    localparam int ID_BASE_W = 11;
    localparam int ID_EXT_W = 29;
    localparam int MAX_DATA_BYTES = 8;
    // nominal bit times
    localparam int CLK_MHZ = 250;
    localparam int BIT_NS_1000K = 1000;
    localparam int BIT_NS_500K = 2000;
    localparam int BIT_NS_250K = 4000;
    localparam int BIT_NS_125K = 8000;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int BIT_CYC_1000K = BIT_NS_1000K / CLK_NS;
    localparam int BIT_CYC_500K = BIT_NS_500K / CLK_NS;
    localparam int BIT_CYC_250K = BIT_NS_250K / CLK_NS;
    localparam int BIT_CYC_125K = BIT_NS_125K / CLK_NS;
    localparam int IDLE_BITS = 11;
    typedef enum logic [4:0] {
        CFH_IDLE = 5'h01,
        CFH_WAIT = 5'h02,
        CFH_SEND = 5'h04,
        CFH_RECV = 5'h08,
        CFH_DONE = 5'h10
    } cfh_state_e;
endpackage : cfh_pkg

// *** design/cfh_bit_timer.sv ***
// bit clock divider: one-cycle pulses at sample point and bit end
`timescale 1ns/1ps
module cfh_bit_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] baudSel,
    input wire logic resync,
    output logic samplePulse,
    output logic bitPulse
);
    typedef struct packed {
        logic [12:0] cnt;
        logic smp;
        logic bit_;
    } cfh_tmr_s;
    cfh_tmr_s st_reg;
    cfh_tmr_s st_next;
    logic [12:0] period;
    always_comb begin
        unique case (baudSel)
            2'h0: period = 13'(cfh_pkg::BIT_CYC_1000K);
            2'h1: period = 13'(cfh_pkg::BIT_CYC_500K);
            2'h2: period = 13'(cfh_pkg::BIT_CYC_250K);
            2'h3: period = 13'(cfh_pkg::BIT_CYC_125K);
        endcase
    end
    always_comb begin
        st_next = st_reg;
        st_next.smp = 1'b0;
        st_next.bit_ = 1'b0;
        if (resync) begin
            st_next.cnt = 13'h0001;
        end else if (st_reg.cnt >= period - 13'h0001) begin
            st_next.cnt = 13'h0000;
            st_next.bit_ = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 13'h0001;
        end
        // sample late in the bit, past propagation settling
        if (!resync && st_reg.cnt == ((period * 13'h0003) >> 2)) begin
            st_next.smp = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign samplePulse = st_reg.smp;
    assign bitPulse = st_reg.bit_;
endmodule : cfh_bit_timer

// *** design/cfh_apb_regs.sv ***
// apb slave holding control, identifier and sdo configuration
`timescale 1ns/1ps
module cfh_apb_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic busy,
    input wire logic lost,
    input wire logic done,
    input wire logic [28:0] rxId,
    input wire logic [10:0] sdoTx,
    input wire logic [10:0] sdoRx,
    output logic goPulse,
    output logic extFmt,
    output logic rtrReq,
    output logic useProgId,
    output logic [1:0] baudSel,
    output logic [28:0] txId,
    output logic [6:0] nodeId,
    output logic [6:0] programmingAccessId
);
    typedef struct packed {
        logic go;
        logic ext;
        logic rtr;
        logic sel;
        logic [1:0] baud;
        logic [28:0] id;
        logic [6:0] node;
        logic [6:0] prog;
        logic lostF;
        logic doneF;
        logic [31:0] rd;
        logic rdy;
        logic err;
    } cfh_regs_s;
    cfh_regs_s st_reg;
    cfh_regs_s st_next;
    logic acc;
    logic wr;
    logic clr;
    logic hit;
    always_comb begin
        acc = psel && penable && !st_reg.rdy;
        wr = acc && pwrite;
        clr = wr && paddr == cfh_pkg::STATUS_OFF;
        hit = paddr == cfh_pkg::CTRL_OFF || paddr == cfh_pkg::IDENT_OFF
            || paddr == cfh_pkg::SDOCFG_OFF || paddr == cfh_pkg::STATUS_OFF
            || paddr == cfh_pkg::SDOID_OFF || paddr == cfh_pkg::RXID_OFF;
        st_next = st_reg;
        st_next.go = 1'b0;
        st_next.rdy = acc;
        st_next.err = acc && !hit;
        // write one to clear; a new event in the same cycle wins
        if (clr && pwdata[0]) st_next.lostF = 1'b0;
        if (clr && pwdata[1]) st_next.doneF = 1'b0;
        if (lost) st_next.lostF = 1'b1;
        if (done) st_next.doneF = 1'b1;
        if (wr && paddr == cfh_pkg::CTRL_OFF) begin
            st_next.go = pwdata[cfh_pkg::CTRL_GO_BIT] && !busy;
            st_next.ext = pwdata[cfh_pkg::CTRL_EXT_BIT];
            st_next.rtr = pwdata[cfh_pkg::CTRL_RTR_BIT];
            st_next.sel = pwdata[cfh_pkg::CTRL_SEL_BIT];
            st_next.baud = pwdata[cfh_pkg::CTRL_BAUD_LSB +: 2];
        end
        if (wr && paddr == cfh_pkg::IDENT_OFF) st_next.id = pwdata[28:0];
        if (wr && paddr == cfh_pkg::SDOCFG_OFF) begin
            st_next.node = pwdata[6:0];
            st_next.prog = pwdata[14:8];
        end
        st_next.rd = 32'h0000_0000;
        if (acc && !pwrite) begin
            unique case (paddr)
                cfh_pkg::CTRL_OFF: st_next.rd = {26'h0, st_reg.baud,
                    st_reg.sel, st_reg.rtr, st_reg.ext, 1'b0};
                cfh_pkg::IDENT_OFF: st_next.rd = {3'h0, st_reg.id};
                cfh_pkg::SDOCFG_OFF: st_next.rd = {17'h0, st_reg.prog,
                    1'b0, st_reg.node};
                cfh_pkg::STATUS_OFF: st_next.rd = {29'h0, busy,
                    st_reg.doneF, st_reg.lostF};
                cfh_pkg::SDOID_OFF: st_next.rd = {5'h0, sdoRx, 5'h0, sdoTx};
                cfh_pkg::RXID_OFF: st_next.rd = {3'h0, rxId};
                default: st_next.rd = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.baud <= cfh_pkg::CTRL_BAUD_RST;
        end else begin
            st_reg <= st_next;
        end
    end
    assign prdata = st_reg.rd;
    assign pready = st_reg.rdy;
    assign pslverr = st_reg.err;
    assign goPulse = st_reg.go;
    assign extFmt = st_reg.ext;
    assign rtrReq = st_reg.rtr;
    assign useProgId = st_reg.sel;
    assign baudSel = st_reg.baud;
    assign txId = st_reg.id;
    assign nodeId = st_reg.node;
    assign programmingAccessId = st_reg.prog;
endmodule : cfh_apb_regs

// *** design/cfh_frame_header.sv ***
// top: can frame header sender with arbitration and sdo identifiers
//
// Notes on behaviour
// - bus is dominant if any node drives; recessive only when none does.
// - nominal bit time follows baud: 1, 2, 4 or 8 microseconds.
// - smaller identifier wins the bus over any larger identifier.
// - base identifiers are 11 bits, extended 29 bits, all values usable.
// - extended ids send bits 28..18 first, bits 17..0 after control bits.
// - a frame starts with a recessive to dominant start bit.
// - rtr dominant for data frames, recessive for remote requests.
// - ide dominant for base format, recessive for extended format.
// - extended frames send a recessive srr where base frames place rtr.
// - sdo ids are 0x580 plus id toward master, 0x600 from master.
// - programming access uses its own id on the same sdo bases.
// - device programming-access id must match the host tool's id.
// - a message holds one identifier and at most eight data bytes.
`timescale 1ns/1ps
module cfh_frame_header (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic canRx,
    output logic canTxDominant
);
    typedef struct packed {
        cfh_pkg::cfh_state_e st;
        logic [1:0] rstSync;
        logic [1:0] rxSync;
        logic rxPrev;
        logic txDom;
        logic [5:0] pos;
        logic [5:0] len;
        logic [3:0] idle;
        logic [34:0] shift;
        logic [28:0] rxId;
        logic lost;
        logic done;
        logic [10:0] sdoTx;
        logic [10:0] sdoRx;
    } cfh_top_s;
    cfh_top_s st_reg;
    cfh_top_s st_next;
    logic rst_n;
    logic goPulse;
    logic extFmt;
    logic rtrReq;
    logic useProgId;
    logic [1:0] baudSel;
    logic [28:0] txId;
    logic [6:0] nodeId;
    logic [6:0] programmingAccessId;
    logic samplePulse;
    logic bitPulse;
    logic rxBit;
    logic sofEdge;
    logic [34:0] hdr;
    logic [6:0] sdoKey;
    assign rst_n = st_reg.rstSync[1];
    assign rxBit = st_reg.rxSync[1];
    // hard sync on the falling edge into dominant while waiting to send
    assign sofEdge = st_reg.rxPrev && !rxBit;
    cfh_apb_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .busy(st_reg.st != cfh_pkg::CFH_IDLE),
        .lost(st_reg.lost),
        .done(st_reg.done),
        .rxId(st_reg.rxId),
        .sdoTx(st_reg.sdoTx),
        .sdoRx(st_reg.sdoRx),
        .goPulse(goPulse),
        .extFmt(extFmt),
        .rtrReq(rtrReq),
        .useProgId(useProgId),
        .baudSel(baudSel),
        .txId(txId),
        .nodeId(nodeId),
        .programmingAccessId(programmingAccessId)
    );
    cfh_bit_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .baudSel(baudSel),
        .resync(st_reg.st == cfh_pkg::CFH_WAIT && sofEdge),
        .samplePulse(samplePulse),
        .bitPulse(bitPulse)
    );
    // header bits in send order, msb first; 1 = dominant
    always_comb begin
        if (extFmt) begin
            hdr = {1'b1, ~txId[28:18], 1'b0, 1'b0,
                ~txId[17:0], ~rtrReq, 2'b00};
        end else begin
            hdr = {1'b1, ~txId[28:18], ~rtrReq, 1'b1,
                21'h000000};
        end
    end
    assign sdoKey = useProgId ? programmingAccessId : nodeId;
    always_comb begin
        st_next = st_reg;
        st_next.rstSync = {st_reg.rstSync[0], 1'b1};
        st_next.rxSync = {st_reg.rxSync[0], canRx};
        st_next.rxPrev = rxBit;
        st_next.lost = 1'b0;
        st_next.done = 1'b0;
        st_next.sdoTx = cfh_pkg::SDO_TX_BASE + {4'h0, sdoKey};
        st_next.sdoRx = cfh_pkg::SDO_RX_BASE + {4'h0, sdoKey};
        unique case (st_reg.st)
            cfh_pkg::CFH_IDLE: begin
                st_next.txDom = 1'b0;
                if (goPulse) begin
                    st_next.st = cfh_pkg::CFH_WAIT;
                    st_next.shift = hdr;
                    st_next.len = extFmt ? 6'h23 : 6'h0E;
                    st_next.idle = 4'h0;
                    st_next.pos = 6'h00;
                end
            end
            cfh_pkg::CFH_WAIT: begin
                // join a frame another node started, else start after idle
                if (sofEdge) begin
                    st_next.st = cfh_pkg::CFH_SEND;
                    st_next.txDom = 1'b1;
                end else if (bitPulse) begin
                    if (!rxBit) begin
                        st_next.idle = 4'h0;
                    end else if (st_reg.idle ==
                        4'(cfh_pkg::IDLE_BITS - 1)) begin
                        st_next.st = cfh_pkg::CFH_SEND;
                        st_next.txDom = 1'b1;
                    end else begin
                        st_next.idle = st_reg.idle + 4'h1;
                    end
                end
            end
            cfh_pkg::CFH_SEND: begin
                if (samplePulse) begin
                    st_next.rxId = {st_reg.rxId[27:0], rxBit};
                    // recessive sent, dominant seen: lower id won
                    if (!st_reg.shift[34] && !rxBit) begin
                        st_next.st = cfh_pkg::CFH_RECV;
                        st_next.txDom = 1'b0;
                        st_next.lost = 1'b1;
                    end
                end
                if (bitPulse && st_reg.st == st_next.st) begin
                    st_next.shift = {st_reg.shift[33:0], 1'b0};
                    st_next.pos = st_reg.pos + 6'h01;
                    st_next.txDom = st_reg.shift[33];
                    if (st_reg.pos + 6'h01 == st_reg.len) begin
                        st_next.st = cfh_pkg::CFH_DONE;
                        st_next.txDom = 1'b0;
                    end
                end
            end
            cfh_pkg::CFH_RECV: begin
                // listen only to the end of the header field
                if (samplePulse) st_next.rxId = {st_reg.rxId[27:0], ~rxBit};
                if (bitPulse) begin
                    st_next.pos = st_reg.pos + 6'h01;
                    if (st_reg.pos + 6'h01 == st_reg.len) begin
                        st_next.st = cfh_pkg::CFH_IDLE;
                    end
                end
            end
            cfh_pkg::CFH_DONE: begin
                // data and crc are outside this block; release the line
                st_next.txDom = 1'b0;
                st_next.done = 1'b1;
                st_next.st = cfh_pkg::CFH_IDLE;
            end
            default: begin
                st_next.st = cfh_pkg::CFH_IDLE;
                st_next.txDom = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.st <= cfh_pkg::CFH_IDLE;
            st_reg.rxSync <= 2'h3;
            st_reg.rxPrev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
    // only dominant is ever driven; recessive means driver off
    assign canTxDominant = st_reg.txDom;
endmodule : cfh_frame_header

// *** testbench/cfh_frame_monitor.sv ***
// checker: apb handshake and bus drive rules at the top ports
`timescale 1ns/1ps
module cfh_frame_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic canRx,
    input wire logic canTxDominant
);
    logic [11:0] domRun;
    logic [11:0] lowRun;
    logic [11:0] recRun;
    logic lostFlag;
    // lost: another node holds the bus dominant while we are off;
    // cleared after the line reads recessive for four cycles, as frames restart fast
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            domRun <= 12'h000;
            lowRun <= 12'h000;
            recRun <= 12'h000;
            lostFlag <= 1'b0;
        end else begin
            domRun <= canTxDominant ? domRun + 12'h001 : 12'h000;
            lowRun <= (!canTxDominant && !canRx) ? lowRun + 12'h001 : 12'h000;
            recRun <= canRx ? recRun + 12'h001 : 12'h000;
            if (lowRun == 12'h12C) begin
                lostFlag <= 1'b1;
            end else if (recRun == 12'h004) begin
                lostFlag <= 1'b0;
            end
        end
    end
    sequence apbWait;
        psel && penable && !pready;
    endsequence
    AST_READY_ONE_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
        apbWait |=> pready) else $error("access not answered in one wait");
    AST_READY_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
        pready |=> !pready) else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (@(posedge clk) disable iff (!arst_n)
        pslverr |-> pready) else $error("pslverr without pready");
    AST_UNMAPPED_ERR: assert property (@(posedge clk) disable iff (!arst_n)
        apbWait ##0 (paddr > 8'h14) |=> pslverr) else $error("no pslverr");
    AST_DATA_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
        !pready |-> prdata == 32'h0) else $error("prdata outside answer");
    AST_BIT_QUANTUM: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(canTxDominant) |-> domRun % 12'h0FA == 12'h000)
        else $error("dominant run not whole bits");
    AST_LOST_RELEASE: assert property (@(posedge clk) disable iff (!arst_n)
        lostFlag |-> !canTxDominant) else $error("drive after losing");
    AST_RESET_QUIET: assert property (@(posedge clk)
        !arst_n |-> !canTxDominant && !pready) else $error("active in reset");
endmodule : cfh_frame_monitor

bind cfh_frame_header cfh_frame_monitor mon_u (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .canRx(canRx),
    .canTxDominant(canTxDominant));

// *** testbench/cfh_can_node.sv ***
// model of another node on the shared line: sends or records a header
`timescale 1ns/1ps
module cfh_can_node (
    input wire logic clk,
    input wire logic busLevel,
    input wire logic start,
    input wire logic arm,
    input wire logic [34:0] txBits,
    input wire logic [5:0] frameLen,
    input wire logic [11:0] bitCyc,
    output logic drvDom,
    output logic [34:0] rxBits,
    output logic [5:0] rxCount
);
    logic active = 1'b0;
    logic armed = 1'b0;
    logic sending = 1'b0;
    logic lastBus = 1'b1;
    logic [11:0] cnt = 12'h000;
    logic [5:0] idx = 6'h00;
    initial begin
        rxBits = 35'h0;
        rxCount = 6'h00;
    end
    assign drvDom = active && sending && !txBits[6'd34 - idx];
    always @(posedge clk) begin
        lastBus <= busLevel;
        if (arm) begin
            armed <= 1'b1;
        end
        // listen only once per arm, so trailing bits never restart a frame
        if (!active && (start || (armed && lastBus && !busLevel))) begin
            active <= 1'b1;
            sending <= start;
            armed <= 1'b0;
            cnt <= 12'h001;
            idx <= 6'h00;
            rxCount <= 6'h00;
        end else if (active) begin
            cnt <= (cnt == bitCyc) ? 12'h001 : cnt + 12'h001;
            if (cnt == (bitCyc >> 1)) begin
                rxBits <= {rxBits[33:0], busLevel};
                rxCount <= rxCount + 6'h01;
                if (sending && txBits[6'd34 - idx] && !busLevel) begin
                    sending <= 1'b0;
                end
            end
            if (cnt == bitCyc) begin
                idx <= idx + 6'h01;
                if (idx + 6'h01 == frameLen) begin
                    active <= 1'b0;
                end
            end
        end
    end
endmodule : cfh_can_node

// *** testbench/test_cfh_frame_header.sv ***
// bench: apb access, sdo ids, header frames and arbitration
`timescale 1ns/1ps
module test_cfh_frame_header;
    logic clk = 1'b0;
    logic arst_n = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic canTxDominant;
    logic nodeStart = 1'b0;
    logic nodeArm = 1'b0;
    logic [34:0] nodeBits = 35'h0;
    logic [5:0] nodeLen = 6'h0E;
    logic [11:0] nodeCyc = 12'h0FA;
    logic nodeDom;
    logic [34:0] nodeRx;
    logic [5:0] nodeCount;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int total_checks = 0;
    wire canRx = !(canTxDominant || nodeDom);
    cfh_frame_header dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .canRx(canRx),
        .canTxDominant(canTxDominant));
    cfh_can_node node_u (.clk(clk), .busLevel(canRx), .start(nodeStart),
        .arm(nodeArm), .txBits(nodeBits), .frameLen(nodeLen),
        .bitCyc(nodeCyc), .drvDom(nodeDom), .rxBits(nodeRx),
        .rxCount(nodeCount));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk iff pready === 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_status(input int bitNo, input logic val);
        int n;
        n = 0;
        do begin
            apb(1'b0, cfh_pkg::STATUS_OFF, 32'h0);
            n++;
        end while (rd[bitNo] !== val && n < 20000);
        check(64'(rd[bitNo]), 64'(val));
    endtask : wait_status
    task automatic test_sdo_ids();
        apb(1'b0, 8'h18, 32'h0);
        check(64'({err, rd}), 64'(33'h1_0000_0000));
        apb(1'b1, cfh_pkg::SDOCFG_OFF, 32'h0000_017F);
        apb(1'b0, cfh_pkg::SDOCFG_OFF, 32'h0);
        check(64'(rd), 64'(32'h0000_017F));
        apb(1'b0, cfh_pkg::SDOID_OFF, 32'h0);
        check(64'(rd), 64'({5'h00, 11'h67F, 5'h00, 11'h5FF}));
        apb(1'b1, cfh_pkg::CTRL_OFF, 32'h0000_0008);
        apb(1'b0, cfh_pkg::CTRL_OFF, 32'h0);
        check(64'(rd), 64'(32'h0000_0008));
        apb(1'b0, cfh_pkg::SDOID_OFF, 32'h0);
        check(64'(rd), 64'({5'h00, 11'h601, 5'h00, 11'h581}));
        $display("test_sdo_ids done");
    endtask : test_sdo_ids
    task automatic test_header(input logic ext, input logic rtr,
            input logic [28:0] id);
        int n;
        logic [34:0] exp;
        logic [34:0] mask;
        n = 0;
        exp = ext ? {2'b00, id[28:18], 2'b11, id[17:0], rtr}
                  : {22'h0, id[28:18], rtr, 1'b0};
        mask = ext ? 35'h1_FFFF_FFFF : 35'h0_0000_3FFF;
        nodeLen <= ext ? 6'h21 : 6'h0E;
        nodeCyc <= 12'h0FA;
        nodeArm <= 1'b1;
        apb(1'b1, cfh_pkg::IDENT_OFF, {3'h0, id});
        nodeArm <= 1'b0;
        apb(1'b1, cfh_pkg::CTRL_OFF, {28'h0, 1'b0, rtr, ext, 1'b1});
        while (nodeCount !== nodeLen && n < 40000) begin
            @(posedge clk);
            n++;
        end
        check(64'(nodeRx & mask), 64'(exp));
        wait_status(1, 1'b1);
        check(64'(rd[2:0]), 64'(3'b010));
        // own samples of the line, latest in bit 0; r1 and r0 left out
        apb(1'b0, cfh_pkg::RXID_OFF, 32'h0);
        check(64'(ext ? rd[28:2] : rd[13:0]),
            64'(ext ? exp[26:0] : exp[13:0]));
        apb(1'b1, cfh_pkg::STATUS_OFF, 32'h0000_0003);
        $display("test_header ext=%0d done", ext);
    endtask : test_header
    task automatic test_arbitration();
        int n;
        int run;
        logic [11:0] cyc;
        apb(1'b1, cfh_pkg::IDENT_OFF, 32'h1FFC_0000);
        for (int b = 0; b < 4; b++) begin
            cyc = 12'h0FA << b;
            nodeCyc <= cyc;
            nodeLen <= 6'h0E;
            nodeBits <= 35'h0;
            apb(1'b1, cfh_pkg::CTRL_OFF, 32'(b * 16 + 1));
            nodeStart <= 1'b1;
            @(posedge clk);
            nodeStart <= 1'b0;
            n = 0;
            run = 0;
            // count on the falling edge, where the output has settled
            while (canTxDominant !== 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            while (canTxDominant === 1'b1 && run < 5000) begin
                @(negedge clk);
                run++;
            end
            check(64'(run), 64'(cyc));
            while (nodeCount !== 6'h0E && n < 40000) begin
                @(negedge clk);
                n++;
            end
            check(64'(nodeRx[13:0]), 64'(14'h0000));
            wait_status(2, 1'b0);
            check(64'(rd[0]), 64'(1'b1));
            apb(1'b1, cfh_pkg::STATUS_OFF, 32'h0000_0003);
        end
        $display("test_arbitration done");
    endtask : test_arbitration
    task automatic give_verdict();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        // a real falling edge, so the asynchronous reset acts at once
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_sdo_ids();
        test_header(1'b0, 1'b0, 29'h0AD4_0000);
        test_header(1'b1, 1'b1, 29'h1234_5678);
        test_arbitration();
        give_verdict();
    end
    // about a third above the expected run, mostly the slow-rate frames
    initial begin
        #380000;
        failures++;
        give_verdict();
    end
endmodule : test_cfh_frame_header
